// ---- bste_pkg.sv ----
// constants, field layouts and enumerations for the bit/shift/transfer execute block
package bste_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	localparam logic [ADDR_W-1:0] OFF_CMD = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_ARG = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_FLAGS = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_STATE = 12'h00c;
	localparam logic [ADDR_W-1:0] OFF_SP = 12'h010;
	localparam logic [ADDR_W-1:0] OFF_GPR = 12'h100;

	localparam int CMD_OP_LSB = 0;
	localparam int CMD_D_LSB = 8;
	localparam int CMD_R_LSB = 16;
	localparam int CMD_B_LSB = 24;
	localparam int CMD_R0_BIT = 27;
	localparam int CMD_PS_LSB = 28;
	localparam int CMD_MD_LSB = 30;

	localparam int FLG_C = 0;
	localparam int FLG_Z = 1;
	localparam int FLG_N = 2;
	localparam int FLG_V = 3;
	localparam int FLG_S = 4;
	localparam int FLG_H = 5;
	localparam int FLG_T = 6;
	localparam int FLG_I = 7;

	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] GPR_RST = 8'h00;
	localparam logic [15:0] SP_RST = 16'h0fff;
	localparam logic [4:0] PTR_BASE = 5'h1a;

	localparam logic [1:0] CYC_SHORT = 2'h1;
	localparam logic [1:0] CYC_MEM = 2'h2;
	localparam logic [1:0] CYC_PMEM = 2'h3;

	typedef enum logic [1:0] {ps_x, ps_y, ps_z, ps_rsv} bste_ptr_e;
	typedef enum logic [1:0] {md_plain, md_postinc, md_predec, md_displaced} bste_mode_e;

	typedef enum logic [4:0] {
		op_set_io_bit, op_clear_io_bit, op_shift_left_logical, op_shift_right_logical,
		op_shift_right_arith, op_rotate_left_carry, op_rotate_right_carry, op_swap_nibbles,
		op_store_bit_to_transfer_flag, op_load_bit_from_transfer_flag, op_flag_set,
		op_flag_clear, op_copy_register, op_copy_register_pair, op_port_in, op_port_out,
		op_load_indirect, op_load_direct, op_write_indirect, op_write_direct,
		op_program_memory_fetch, op_stack_push, op_stack_pop, op_sleep,
		op_watchdog_restart, op_nop
	} bste_op_e;

endpackage : bste_pkg

// ---- bste_core.sv ----
// execute unit for bit, shift, flag, transfer and control instructions with an apb slave
// Operation
// (RULE1) set or clear one i/o register bit in two cycles, flags untouched
// (RULE2) left logical shift, zero into bit 0, updates z c n v, one cycle
// (RULE3) right logical shift, zero into bit 7, updates z c n v, one cycle
// (RULE4) arithmetic right shift keeps bit 7, updates z c n v, one cycle
// (RULE5) rotate left through carry, old bit 7 to carry, one cycle
// (RULE6) rotate right through carry, old bit 0 to carry, one cycle
// (RULE7) copy selected register bit into transfer flag, one cycle
// (RULE8) copy transfer flag into selected register bit, one cycle, flags untouched
// (RULE9) flag instructions set or clear exactly one status flag in one cycle
// (RULE10) post-increment indirect load reads then bumps pointer, two cycles
// (RULE11) pre-decrement indirect load drops pointer then reads, two cycles
// (RULE12) displaced load from y or z plus offset, pointer kept, two cycles
// (RULE13) direct load from immediate address in two cycles, flags untouched
// (RULE14) post-increment indirect store writes then bumps pointer, two cycles
// (RULE15) pre-decrement indirect store drops pointer then writes, two cycles
// (RULE16) displaced store to y or z plus offset, pointer kept, two cycles
// (RULE17) direct store to immediate address in two cycles, flags untouched
// (RULE18) program memory byte at z into rd or r0, optional post-increment, three cycles
// (RULE19) push writes register onto stack in two cycles, flags untouched
// (RULE20) pop reads stack top into register in two cycles, flags untouched
// (RULE21) sleep takes one cycle, signals the sleep logic, flags untouched
// (RULE22) watchdog restart takes one cycle, signals the watchdog, flags untouched
// (RULE23) register or aligned pair copy in one cycle, no flag effect
// (RULE24) port in and out move one byte in one cycle, flags untouched
// (RULE25) nibble swap of destination in one cycle, flags untouched
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/10ps
module bste_core import bste_pkg::*; #(
	parameter logic [15:0] SP_INIT = SP_RST
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [15:0] dmem_addr,
	output logic [7:0] dmem_wdata,
	output logic dmem_we,
	output logic dmem_re,
	input wire logic [7:0] dmem_rdata,
	output logic [5:0] io_addr,
	output logic [7:0] io_wdata,
	output logic io_we,
	output logic io_re,
	input wire logic [7:0] io_rdata,
	output logic [15:0] pmem_addr,
	output logic pmem_re,
	input wire logic [7:0] pmem_rdata,
	output logic sleep_req,
	output logic wdog_restart,
	output logic busy
);

	logic [7:0] gpr [32];
	logic [7:0] status_flags_r;
	logic [15:0] sp_r;
	logic [31:0] cmd_r;
	logic [31:0] arg_r;
	logic [1:0] cyc_r;
	bste_op_e op_r;
	logic [4:0] d_r;
	logic [4:0] r_r;
	logic [2:0] b_r;
	bste_ptr_e ps_r;
	bste_mode_e md_r;

	function automatic logic [4:0] ptr_base(input bste_ptr_e ps);
		return 5'(PTR_BASE + {ps, 1'b0});
	endfunction : ptr_base

	function automatic logic [1:0] op_cycles(input bste_op_e op);
		unique case (op)
			op_set_io_bit, op_clear_io_bit, op_load_indirect, op_load_direct,
			op_write_indirect, op_write_direct, op_stack_push, op_stack_pop: return CYC_MEM;
			op_program_memory_fetch: return CYC_PMEM;
			default: return CYC_SHORT;
		endcase
	endfunction : op_cycles

	// z, c, n, v after a shift or rotate; v follows n xor c
	function automatic logic [7:0] shift_flags(input logic [7:0] f, input logic [7:0] res,
			input logic c);
		logic [7:0] o;
		o = f;
		o[FLG_Z] = (res == 8'h00);
		o[FLG_C] = c;
		o[FLG_N] = res[7];
		o[FLG_V] = res[7] ^ c;
		return o;
	endfunction : shift_flags

	// apb decode
	logic setup;
	logic acc_wr;
	logic sel_cmd, sel_arg, sel_flags, sel_state, sel_sp, sel_gpr;
	logic [4:0] gpr_idx;
	logic err_nxt;
	logic [31:0] rd_mux;
	assign setup = psel && !penable;
	assign acc_wr = psel && penable && pready && pwrite && !pslverr;
	assign sel_cmd = (paddr == OFF_CMD);
	assign sel_arg = (paddr == OFF_ARG);
	assign sel_flags = (paddr == OFF_FLAGS);
	assign sel_state = (paddr == OFF_STATE);
	assign sel_sp = (paddr == OFF_SP);
	assign sel_gpr = (paddr[ADDR_W-1:7] == OFF_GPR[ADDR_W-1:7]) && (paddr[1:0] == 2'h0);
	assign gpr_idx = paddr[6:2];

	// command fields as written
	bste_op_e c_op;
	bste_ptr_e c_ps;
	bste_mode_e c_md;
	logic [4:0] c_d, c_r;
	logic c_legal, c_ptr_op;
	logic [15:0] c_ptr, c_ea;
	assign c_op = bste_op_e'(pwdata[CMD_OP_LSB +: 5]);
	assign c_md = bste_mode_e'(pwdata[CMD_MD_LSB +: 2]);
	assign c_ps = (c_op == op_program_memory_fetch) ? ps_z : bste_ptr_e'(pwdata[CMD_PS_LSB +: 2]);
	assign c_r = (c_op == op_copy_register_pair) ? {pwdata[CMD_R_LSB+1 +: 4], 1'b0}
		: pwdata[CMD_R_LSB +: 5];
	always_comb begin
		c_d = pwdata[CMD_D_LSB +: 5];
		if (c_op == op_copy_register_pair) begin
			c_d = {pwdata[CMD_D_LSB+1 +: 4], 1'b0}; // RULE23
		end
		if (c_op == op_program_memory_fetch && pwdata[CMD_R0_BIT]) begin
			c_d = 5'h00; // RULE18
		end
	end
	assign c_ptr_op = (c_op == op_load_indirect) || (c_op == op_write_indirect);
	// displacement exists only on y and z; x with offset or the spare select is refused
	assign c_legal = (pwdata[CMD_OP_LSB +: 5] <= 5'(op_nop)) && !(c_ptr_op && (c_ps == ps_rsv
		|| (c_md == md_displaced && c_ps == ps_x)))
		&& !(c_op == op_program_memory_fetch && c_md != md_plain && c_md != md_postinc); // RULE12
	assign c_ptr = {gpr[5'(ptr_base(c_ps) + 5'h01)], gpr[ptr_base(c_ps)]};

	always_comb begin
		c_ea = c_ptr;
		if (c_op == op_load_direct || c_op == op_write_direct) begin
			c_ea = arg_r[15:0]; // RULE13 RULE17
		end else if (c_op == op_stack_push) begin
			c_ea = sp_r; // RULE19
		end else if (c_op == op_stack_pop) begin
			c_ea = 16'(sp_r + 16'h0001); // RULE20
		end else if (c_md == md_predec) begin
			c_ea = 16'(c_ptr - 16'h0001); // RULE11 RULE15
		end else if (c_md == md_displaced) begin
			c_ea = 16'(c_ptr + {10'h000, arg_r[5:0]}); // RULE12 RULE16
		end
	end

	always_comb begin
		err_nxt = !(sel_cmd || sel_arg || sel_flags || sel_state || sel_sp || sel_gpr);
		if (pwrite && busy && (sel_cmd || sel_flags || sel_sp || sel_gpr || sel_arg)) begin
			err_nxt = 1'b1;
		end
		if (pwrite && sel_cmd && !c_legal) begin
			err_nxt = 1'b1;
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (sel_cmd) rd_mux = cmd_r;
		if (sel_arg) rd_mux = arg_r;
		if (sel_flags) rd_mux = {24'h00_0000, status_flags_r};
		if (sel_state) rd_mux = {29'h0000_0000, cyc_r, busy};
		if (sel_sp) rd_mux = {16'h0000, sp_r};
		if (sel_gpr) rd_mux = {24'h00_0000, gpr[gpr_idx]};
	end

	// answer registered in setup, so every access is exactly two cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= setup;
			pslverr <= setup && err_nxt;
			prdata <= (setup && !pwrite && !err_nxt) ? rd_mux : 32'h0000_0000;
		end
	end

	logic launch;
	logic done;
	assign launch = acc_wr && sel_cmd;
	assign done = busy && (cyc_r == 2'(op_cycles(op_r) - 2'h1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arg_r <= 32'h0000_0000;
		end else if (acc_wr && sel_arg) begin
			arg_r <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy <= 1'b0;
			cyc_r <= 2'h0;
			cmd_r <= 32'h0000_0000;
			op_r <= op_nop;
			d_r <= 5'h00;
			r_r <= 5'h00;
			b_r <= 3'h0;
			ps_r <= ps_x;
			md_r <= md_plain;
		end else if (launch) begin
			busy <= 1'b1;
			cyc_r <= 2'h0;
			cmd_r <= pwdata;
			op_r <= c_op;
			d_r <= c_d;
			r_r <= c_r;
			b_r <= pwdata[CMD_B_LSB +: 3];
			ps_r <= c_ps;
			md_r <= c_md;
		end else if (done) begin
			busy <= 1'b0;
			cyc_r <= 2'h0;
		end else if (busy) begin
			cyc_r <= 2'(cyc_r + 2'h1);
		end
	end

	// execution datapath
	logic [7:0] rd_val, rr_val, res;
	logic [7:0] fl;
	logic wr_d, ptr_upd;
	logic [4:0] pbase;
	logic [15:0] ptr_cur, ptr_new;
	assign rd_val = gpr[d_r];
	assign rr_val = gpr[r_r];
	assign pbase = ptr_base(ps_r);
	assign ptr_cur = {gpr[5'(pbase + 5'h01)], gpr[pbase]};
	assign ptr_new = (md_r == md_predec) ? 16'(ptr_cur - 16'h0001)
		: 16'(ptr_cur + 16'h0001); // RULE10 RULE11 RULE14 RULE15
	assign ptr_upd = ((op_r == op_load_indirect || op_r == op_write_indirect)
		&& (md_r == md_postinc || md_r == md_predec))
		|| (op_r == op_program_memory_fetch && md_r == md_postinc); // RULE18

	always_comb begin
		res = rd_val;
		fl = status_flags_r;
		wr_d = 1'b0;
		unique case (op_r)
			op_shift_left_logical: begin
				res = {rd_val[6:0], 1'b0}; // RULE2
				fl = shift_flags(status_flags_r, res, rd_val[7]);
				wr_d = 1'b1;
			end
			op_shift_right_logical: begin
				res = {1'b0, rd_val[7:1]}; // RULE3
				fl = shift_flags(status_flags_r, res, rd_val[0]);
				wr_d = 1'b1;
			end
			op_shift_right_arith: begin
				res = {rd_val[7], rd_val[7:1]}; // RULE4
				fl = shift_flags(status_flags_r, res, rd_val[0]);
				wr_d = 1'b1;
			end
			op_rotate_left_carry: begin
				res = {rd_val[6:0], status_flags_r[FLG_C]}; // RULE5
				fl = shift_flags(status_flags_r, res, rd_val[7]);
				wr_d = 1'b1;
			end
			op_rotate_right_carry: begin
				res = {status_flags_r[FLG_C], rd_val[7:1]}; // RULE6
				fl = shift_flags(status_flags_r, res, rd_val[0]);
				wr_d = 1'b1;
			end
			op_swap_nibbles: begin
				res = {rd_val[3:0], rd_val[7:4]}; // RULE25
				wr_d = 1'b1;
			end
			op_store_bit_to_transfer_flag: fl[FLG_T] = rr_val[b_r]; // RULE7
			op_load_bit_from_transfer_flag: begin
				res[b_r] = status_flags_r[FLG_T]; // RULE8
				wr_d = 1'b1;
			end
			op_flag_set: fl[b_r] = 1'b1; // RULE9
			op_flag_clear: fl[b_r] = 1'b0; // RULE9
			op_copy_register: begin
				res = rr_val; // RULE23
				wr_d = 1'b1;
			end
			op_port_in: begin
				res = io_rdata; // RULE24
				wr_d = 1'b1;
			end
			op_load_indirect, op_load_direct, op_stack_pop: begin
				res = dmem_rdata; // RULE10 RULE11 RULE12 RULE13 RULE20
				wr_d = 1'b1;
			end
			op_program_memory_fetch: begin
				res = pmem_rdata; // RULE18
				wr_d = 1'b1;
			end
			op_set_io_bit, op_clear_io_bit, op_copy_register_pair, op_port_out,
			op_write_indirect, op_write_direct, op_stack_push, op_sleep,
			op_watchdog_restart, op_nop: begin
			end
		endcase
	end

	// pointer write comes last so it wins if a load targets its own pointer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 32; i++) begin
				gpr[i] <= GPR_RST;
			end
		end else if (acc_wr && sel_gpr) begin
			gpr[gpr_idx] <= pwdata[7:0];
		end else if (done) begin
			if (wr_d) begin
				gpr[d_r] <= res;
			end
			if (op_r == op_copy_register_pair) begin
				gpr[d_r] <= rr_val; // RULE23
				gpr[{d_r[4:1], 1'b1}] <= gpr[{r_r[4:1], 1'b1}];
			end
			if (ptr_upd) begin
				gpr[pbase] <= ptr_new[7:0];
				gpr[5'(pbase + 5'h01)] <= ptr_new[15:8];
			end
		end
	end

	// only flag-touching ops change fl, so the rest leave the flags as they were
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_flags_r <= FLAGS_RST;
		end else if (acc_wr && sel_flags) begin
			status_flags_r <= pwdata[7:0];
		end else if (done) begin
			status_flags_r <= fl; // RULE1 RULE8 RULE21 RULE22
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sp_r <= SP_INIT;
		end else if (acc_wr && sel_sp) begin
			sp_r <= pwdata[15:0];
		end else if (done && op_r == op_stack_push) begin
			sp_r <= 16'(sp_r - 16'h0001); // RULE19
		end else if (done && op_r == op_stack_pop) begin
			sp_r <= 16'(sp_r + 16'h0001); // RULE20
		end
	end

	// requests are issued on the launch edge and read data is sampled on the last edge, except set/clear io bit, which samples and writes one edge after launch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dmem_addr <= 16'h0000;
			dmem_wdata <= 8'h00;
			dmem_we <= 1'b0;
			dmem_re <= 1'b0;
			io_addr <= 6'h00;
			io_wdata <= 8'h00;
			io_we <= 1'b0;
			io_re <= 1'b0;
			pmem_addr <= 16'h0000;
			pmem_re <= 1'b0;
			sleep_req <= 1'b0;
			wdog_restart <= 1'b0;
		end else if (launch) begin
			dmem_addr <= c_ea;
			dmem_wdata <= gpr[c_r];
			dmem_re <= (c_op == op_load_indirect) || (c_op == op_load_direct)
				|| (c_op == op_stack_pop);
			dmem_we <= (c_op == op_write_indirect) || (c_op == op_write_direct)
				|| (c_op == op_stack_push); // RULE14 RULE15 RULE16 RULE17 RULE19
			io_addr <= arg_r[5:0];
			io_wdata <= gpr[c_r];
			io_re <= (c_op == op_set_io_bit) || (c_op == op_clear_io_bit)
				|| (c_op == op_port_in);
			io_we <= (c_op == op_port_out); // RULE24
			pmem_addr <= c_ea;
			pmem_re <= (c_op == op_program_memory_fetch);
			sleep_req <= (c_op == op_sleep); // RULE21
			wdog_restart <= (c_op == op_watchdog_restart); // RULE22
		end else begin
			dmem_we <= 1'b0;
			io_we <= 1'b0;
			sleep_req <= 1'b0;
			wdog_restart <= 1'b0;
			if (busy && cyc_r == 2'h0
				&& (op_r == op_set_io_bit || op_r == op_clear_io_bit)) begin
				io_re <= 1'b0;
				io_we <= 1'b1;
				io_wdata <= (op_r == op_set_io_bit) ? (io_rdata | (8'h01 << b_r))
					: (io_rdata & ~(8'h01 << b_r)); // RULE1
			end
			if (done) begin
				dmem_re <= 1'b0;
				io_re <= 1'b0;
				pmem_re <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	io_bit_write_a: assert property ( // RULE1
		$rose(io_we) && op_r == op_set_io_bit |-> io_wdata[b_r] && busy && cyc_r == 2'h1)
		else $error("set_io_bit write lacks the bit or lands in the wrong cycle");
	io_bit_len_a: assert property ( // RULE1
		launch && (c_op == op_clear_io_bit) |=> busy [*2] ##1 !busy)
		else $error("clear_io_bit did not take two cycles");
	shl_result_a: assert property ( // RULE2
		done && op_r == op_shift_left_logical |=> gpr[$past(d_r)] == {$past(rd_val[6:0]), 1'b0}
		&& status_flags_r[FLG_C] == $past(rd_val[7]))
		else $error("left shift result or carry wrong");
	shr_result_a: assert property ( // RULE3
		done && op_r == op_shift_right_logical |=> !gpr[$past(d_r)][7]
		&& status_flags_r[FLG_C] == $past(rd_val[0]))
		else $error("right shift did not load zero or carry wrong");
	arith_keep_a: assert property ( // RULE4
		done && op_r == op_shift_right_arith |=> gpr[$past(d_r)][7:6] == {2{$past(rd_val[7])}})
		else $error("arithmetic shift lost the sign bit");
	rotl_carry_a: assert property ( // RULE5
		done && op_r == op_rotate_left_carry |=> gpr[$past(d_r)][0] == $past(status_flags_r[FLG_C])
		&& status_flags_r[FLG_C] == $past(rd_val[7]))
		else $error("rotate left carry path wrong");
	tflag_copy_a: assert property ( // RULE7
		done && op_r == op_store_bit_to_transfer_flag |=> status_flags_r[FLG_T] == $past(rr_val[b_r])
		&& status_flags_r[5:0] == $past(status_flags_r[5:0]))
		else $error("transfer flag copy wrong");
	flag_hold_a: assert property ( // RULE8
		done && op_r inside {op_load_bit_from_transfer_flag, op_swap_nibbles, op_copy_register,
		op_port_in, op_load_indirect, op_stack_pop} |=> $stable(status_flags_r))
		else $error("flags changed by a flag-neutral instruction");
	postinc_ptr_a: assert property ( // RULE10
		done && ptr_upd && md_r == md_postinc |=> ptr_cur == 16'($past(ptr_cur) + 16'h0001))
		else $error("post-increment pointer wrong");
	predec_addr_a: assert property ( // RULE11
		launch && c_ptr_op && c_md == md_predec |=> dmem_addr == 16'($past(c_ptr) - 16'h0001))
		else $error("pre-decrement address wrong");
	fetch_len_a: assert property ( // RULE18
		launch && c_op == op_program_memory_fetch |=> (busy && pmem_re) [*3] ##1 !busy)
		else $error("program fetch did not take three cycles");
	wdog_pulse_a: assert property ( // RULE22
		$rose(wdog_restart) |-> busy && cyc_r == 2'h0 ##1 !wdog_restart && !busy)
		else $error("watchdog restart not a one-cycle pulse");

	cov_io_set_c: cover property (launch && c_op == op_set_io_bit ##2 !busy);
	cov_push_pop_c: cover property (done && op_r == op_stack_push ##[1:20] done && op_r == op_stack_pop);
	cov_refused_c: cover property (pready && pslverr && pwrite);
	cov_disp_load_c: cover property (launch && c_ptr_op && c_md == md_displaced);

endmodule : bste_core

// ---- bste_mem_model.sv ----
// behavioural data, i/o and program memory facing the execute block
`timescale 1ns/10ps
module bste_mem_model (
	input wire logic pclk,
	input wire logic [15:0] dmem_addr,
	input wire logic [7:0] dmem_wdata,
	input wire logic dmem_we,
	input wire logic dmem_re,
	output logic [7:0] dmem_rdata,
	input wire logic [5:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic io_we,
	input wire logic io_re,
	output logic [7:0] io_rdata,
	input wire logic [15:0] pmem_addr,
	input wire logic pmem_re,
	output logic [7:0] pmem_rdata
);
	logic [7:0] dm [0:4095];
	logic [7:0] io [0:63];
	logic [7:0] pm [0:255];
	logic [7:0] tog = 8'h00;
	initial begin
		for (int i = 0; i < 4096; i++) dm[i] = 8'(i) ^ 8'ha5;
		for (int i = 0; i < 64; i++) io[i] = 8'(i * 3);
		for (int i = 0; i < 256; i++) pm[i] = ~8'(i);
	end
	// unread ports churn so a late sample cannot match by luck
	assign dmem_rdata = dmem_re ? dm[dmem_addr[11:0]] : tog;
	assign io_rdata = io_re ? io[io_addr] : ~tog;
	assign pmem_rdata = pmem_re ? pm[pmem_addr[7:0]] : tog ^ 8'h3c;
	always @(posedge pclk) begin
		tog <= tog + 8'h1d;
		if (dmem_we) dm[dmem_addr[11:0]] <= dmem_wdata;
		if (io_we) io[io_addr] <= io_wdata;
	end
endmodule : bste_mem_model

// ---- tb.sv ----
// self-checking testbench for the bit/shift/transfer execute block
`timescale 1ns/10ps
module tb import bste_pkg::*; ;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0, prdata, q;
	logic pready, pslverr, dmem_we, dmem_re, io_we, io_re, pmem_re, sleep_req, wdog_restart, busy;
	logic [15:0] dmem_addr, pmem_addr;
	logic [7:0] dmem_wdata, dmem_rdata, io_wdata, io_rdata, pmem_rdata;
	logic [5:0] io_addr;
	int n_errors = 0, n_checks = 0, cyc = 0, n_slp = 0, n_wd = 0;
	always #2.5 pclk = ~pclk;
	bste_core i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .dmem_addr, .dmem_wdata, .dmem_we, .dmem_re, .dmem_rdata, .io_addr,
		.io_wdata, .io_we, .io_re, .io_rdata, .pmem_addr, .pmem_re, .pmem_rdata, .sleep_req,
		.wdog_restart, .busy);
	bste_mem_model i_mem (.pclk, .dmem_addr, .dmem_wdata, .dmem_we, .dmem_re, .dmem_rdata,
		.io_addr, .io_wdata, .io_we, .io_re, .io_rdata, .pmem_addr, .pmem_re, .pmem_rdata);
	task automatic print_verdict;
		if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e = 1'b0);
		apb(1'b1, a, d);
		chk({31'h0, err}, {31'h0, e});
	endtask : wr
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rc
	function automatic logic [11:0] ga(input int n);
		return OFF_GPR + 12'(4 * n);
	endfunction : ga
	function automatic logic [31:0] cm(input logic [4:0] op, input logic [4:0] rd = 0,
		input logic [4:0] rr = 0, input logic [2:0] b = 0, input logic [1:0] ps = 0,
		input logic [1:0] md = 0, input logic r0 = 0);
		return {md, ps, r0, b, 3'h0, rr, 3'h0, rd, 3'h0, op};
	endfunction : cm
	// expected {carry, result} of the shift group; swap keeps carry
	function automatic logic [8:0] shf(input int op, input logic [7:0] v, input logic c);
		case (op)
			2: return {v, 1'b0};
			3: return {v[0], 1'b0, v[7:1]};
			4: return {v[0], v[7], v[7:1]};
			5: return {v, c};
			6: return {v[0], c, v[7:1]};
			default: return {c, v[3:0], v[7:4]};
		endcase
	endfunction : shf
	// busy length is counted so a one-cycle slip shows
	task automatic ex(input logic [31:0] c, input logic [15:0] g = 16'h0, input int n = 1);
		int k = 0;
		wr(OFF_ARG, {16'h0, g});
		wr(OFF_CMD, c);
		#1;
		while (busy === 1'b1 && k < 20) begin
			@(posedge pclk);
			#1;
			k++;
		end
		if (n > 0) chk(k, n);
	endtask : ex
	task automatic sp(input int n, input logic [15:0] v);
		wr(ga(n), 32'(v[7:0]));
		wr(ga(n + 1), 32'(v[15:8]));
	endtask : sp
	task automatic cp(input int n, input logic [15:0] v);
		rc(ga(n), 32'(v[7:0]));
		rc(ga(n + 1), 32'(v[15:8]));
	endtask : cp
	task automatic cdm(input int a, input logic [7:0] e);
		chk(32'(i_mem.dm[a]), 32'(e));
	endtask : cdm
	always @(posedge pclk) begin
		cyc++;
		if (sleep_req === 1'b1) n_slp++;
		if (wdog_restart === 1'b1) n_wd++;
		if (cyc == 20000) begin
			n_errors++;
			print_verdict();
		end
	end
	initial begin
		logic [8:0] s;
		logic [7:0] v;
		logic [7:0] f;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rc(OFF_FLAGS, 32'h0);
		rc(OFF_SP, 32'h0fff);
		for (int op = 2; op < 8; op++) begin
			for (int i = 0; i < 3; i++) begin
				v = (i == 0) ? 8'h81 : (i == 1) ? 8'h80 : 8'h01;
				wr(ga(1), 32'(v));
				wr(OFF_FLAGS, {24'h0, 7'h18, i[0]});
				ex(cm(op[4:0], 1));
				s = shf(op, v, i[0]);
				f = (op == 7) ? {7'h18, i[0]} : {4'h3, s[7] ^ s[8], s[7], s[7:0] == 8'h0, s[8]};
				rc(ga(1), 32'(s[7:0]));
				rc(OFF_FLAGS, 32'(f));
			end
		end
		for (int b = 0; b < 8; b++) begin
			wr(OFF_FLAGS, 32'h0);
			ex(cm(op_flag_set, 0, 0, b[2:0]));
			rc(OFF_FLAGS, 32'h1 << b);
			wr(OFF_FLAGS, 32'hff);
			ex(cm(op_flag_clear, 0, 0, b[2:0]));
			rc(OFF_FLAGS, 32'hff ^ (32'h1 << b));
		end
		wr(ga(2), 32'h10);
		wr(ga(3), 32'h0);
		wr(OFF_FLAGS, 32'h0);
		ex(cm(op_store_bit_to_transfer_flag, 0, 2, 3'h4));
		rc(OFF_FLAGS, 32'h40);
		ex(cm(op_load_bit_from_transfer_flag, 3, 0, 3'h0));
		rc(ga(3), 32'h01);
		rc(OFF_FLAGS, 32'h40);
		ex(cm(op_store_bit_to_transfer_flag, 0, 2, 3'h0));
		rc(OFF_FLAGS, 32'h0);
		wr(OFF_FLAGS, 32'hc3);
		ex(cm(op_set_io_bit, 0, 0, 3'h4), 16'h5, 2);
		chk(32'(i_mem.io[5]), 32'h1f);
		ex(cm(op_clear_io_bit, 0, 0, 3'h0), 16'h5, 2);
		chk(32'(i_mem.io[5]), 32'h1e);
		ex(cm(op_port_in, 4), 16'h5);
		rc(ga(4), 32'h1e);
		ex(cm(op_port_out, 0, 4), 16'h9);
		chk(32'(i_mem.io[9]), 32'h1e);
		rc(OFF_FLAGS, 32'hc3);
		sp(26, 16'h0100);
		sp(28, 16'h0200);
		sp(30, 16'h0300);
		ex(cm(op_load_indirect, 5, 0, 0, ps_x, md_postinc), 0, 2);
		rc(ga(5), 32'ha5);
		cp(26, 16'h0101);
		ex(cm(op_load_indirect, 5, 0, 0, ps_y, md_predec), 0, 2);
		rc(ga(5), 32'h5a);
		cp(28, 16'h01ff);
		ex(cm(op_load_indirect, 5, 0, 0, ps_z, md_displaced), 16'h5, 2);
		rc(ga(5), 32'ha0);
		cp(30, 16'h0300);
		ex(cm(op_load_indirect, 5, 0, 0, ps_y, md_plain), 0, 2);
		rc(ga(5), 32'h5a);
		cp(28, 16'h01ff);
		ex(cm(op_load_direct, 5), 16'h0410, 2);
		rc(ga(5), 32'hb5);
		wr(ga(6), 32'h3c);
		ex(cm(op_write_indirect, 0, 6, 0, ps_x, md_postinc), 0, 2);
		cdm(12'h101, 8'h3c);
		cp(26, 16'h0102);
		ex(cm(op_write_indirect, 0, 6, 0, ps_x, md_plain), 0, 2);
		cdm(12'h102, 8'h3c);
		cp(26, 16'h0102);
		ex(cm(op_write_indirect, 0, 6, 0, ps_y, md_predec), 0, 2);
		cdm(12'h1fe, 8'h3c);
		cp(28, 16'h01fe);
		ex(cm(op_write_indirect, 0, 6, 0, ps_z, md_displaced), 16'h7, 2);
		cdm(12'h307, 8'h3c);
		cp(30, 16'h0300);
		ex(cm(op_write_direct, 0, 6), 16'h0420, 2);
		cdm(12'h420, 8'h3c);
		sp(30, 16'h0020);
		ex(cm(op_program_memory_fetch, 7, 0, 0, ps_z, md_postinc), 0, 3);
		rc(ga(7), 32'hdf);
		cp(30, 16'h0021);
		ex(cm(op_program_memory_fetch, 0, 0, 0, ps_z, md_plain, 1'b1), 0, 3);
		rc(ga(0), 32'hde);
		wr(ga(8), 32'h77);
		ex(cm(op_stack_push, 0, 8), 0, 2);
		cdm(12'hfff, 8'h77);
		rc(OFF_SP, 32'h0ffe);
		ex(cm(op_stack_pop, 9), 0, 2);
		rc(ga(9), 32'h77);
		rc(OFF_SP, 32'h0fff);
		ex(cm(op_copy_register, 10, 9));
		rc(ga(10), 32'h77);
		ex(cm(op_copy_register_pair, 12, 26));
		cp(12, 16'h0102);
		ex(cm(op_sleep));
		ex(cm(op_watchdog_restart));
		chk(n_slp, 1);
		chk(n_wd, 1);
		rc(OFF_FLAGS, 32'hc3);
		// refused accesses must leave state alone
		rc(12'h014, 32'h0);
		chk({31'h0, err}, 32'h1);
		wr(OFF_CMD, cm(5'h1a), 1'b1);
		wr(OFF_CMD, cm(op_load_indirect, 5, 0, 0, ps_rsv), 1'b1);
		wr(OFF_CMD, cm(op_load_indirect, 5, 0, 0, ps_x, md_displaced), 1'b1);
		wr(OFF_CMD, cm(op_program_memory_fetch, 7, 0, 0, ps_z));
		wr(OFF_FLAGS, 32'h0, 1'b1);
		repeat (4) @(posedge pclk);
		rc(OFF_FLAGS, 32'hc3);
		wr(OFF_ARG, 32'h0000_5a3c);
		rc(OFF_ARG, 32'h0000_5a3c);
		// status read lands in the second busy cycle: count 1, busy 1
		wr(OFF_CMD, cm(op_program_memory_fetch, 7, 0, 0, ps_z));
		rc(OFF_STATE, 32'h3);
		rc(OFF_CMD, cm(op_program_memory_fetch, 7, 0, 0, ps_z));
		print_verdict();
	end
endmodule : tb
